// ===== src/swdt_defs.svh
// swdt_defs.svh: offsets, field positions, reset values and timing
// figures of the software watchdog.
// assumes: included by bare name from the package and the modules.
`ifndef SWDT_DEFS_SVH
`define SWDT_DEFS_SVH

// register byte offsets on the AXI4-Lite slave
`define SWDT_OFF_CTRL     32'h0000_0000
`define SWDT_OFF_TIMEOUT  32'h0000_0004
`define SWDT_OFF_WINDOW   32'h0000_0008
`define SWDT_OFF_SERVICE  32'h0000_000C
`define SWDT_OFF_COUNT    32'h0000_0010
`define SWDT_OFF_STATUS   32'h0000_0014

// watchdog_control_register fields
`define SWDT_CTRL_W       5
`define SWDT_CR_EN        0
`define SWDT_CR_LOCK      1
`define SWDT_CR_INTF      2
`define SWDT_CR_KEYED     3
`define SWDT_CR_WIN       4
`define SWDT_CTRL_RESET   5'h00
`define SWDT_WINDOW_RESET 32'h0000_0000

// status fields
`define SWDT_ST_IRQ       0
`define SWDT_ST_RST       1
`define SWDT_ST_ARM       2

// fixed service pair and keyed service generator
`define SWDT_SVC_W        16
`define SWDT_SVC_FIRST    16'hA602
`define SWDT_SVC_SECOND   16'hB480
`define SWDT_KEY_MUL      16'h0011
`define SWDT_KEY_ADD      16'h0003
// arbitrary seed value
`define SWDT_KEY_SEED     16'h5A5A

// AXI responses
`define SWDT_RESP_OKAY    2'h0
`define SWDT_RESP_SLVERR  2'h2

// counting clock: nominal kHz, tolerance in percent, default period
`define SWDT_IRC_KHZ      16000
`define SWDT_IRC_TOL_PCT  6
`define SWDT_DEF_PERIOD_US 1000

`endif

// ===== src/swdt_pkg.sv
// swdt_pkg: types shared by the watchdog modules.
// assumes: swdt_defs.svh on the include path.
`include "swdt_defs.svh"

package swdt_pkg;

    // fixed-sequence service progress, one-hot
    typedef enum logic [1:0] {
        SWDT_SVC_IDLE  = 2'b01,
        SWDT_SVC_ARMED = 2'b10
    } swdt_svc_e;

    typedef struct packed {
        logic                      awready;
        logic                      wready;
        logic                      bvalid;
        logic [1:0]                bresp;
        logic                      arready;
        logic                      rvalid;
        logic [1:0]                rresp;
        logic [31:0]               rdata;
        logic                      aw_got;
        logic                      w_got;
        logic [31:0]               waddr;
        logic [31:0]               wdata;
        logic [3:0]                wstrb;
        logic [`SWDT_CTRL_W-1:0]   ctrl;
        logic [31:0]               timeout;
        logic [31:0]               window;
        logic [31:0]               count;
        swdt_svc_e                 svc;
        logic                      irq;
        logic                      rst_req;
        logic                      irc_prev;
    } swdt_state_s;

    typedef struct packed {
        logic [`SWDT_SVC_W-1:0]    key;
    } swdt_key_s;

endpackage : swdt_pkg

// ===== src/swdt_key.sv
// swdt_key: pseudo-random service key for keyed service.
// assumes: advance is a one-cycle pulse from the watchdog core.
`timescale 1ns/10ps
`include "swdt_defs.svh"
module swdt_key
    import swdt_pkg::*;
#(
    parameter logic [`SWDT_SVC_W-1:0] SEED = `SWDT_KEY_SEED
) (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic                   advance,
    output logic [`SWDT_SVC_W-1:0]      key
);

    swdt_key_s                 st;
    swdt_key_s                 next_st;
    logic [2*`SWDT_SVC_W-1:0]  prod;

    // linear congruential step; only the low half is kept on purpose
    always_comb begin
        next_st = st;
        prod    = st.key * `SWDT_KEY_MUL;
        if (advance) begin
            next_st.key = prod[`SWDT_SVC_W-1:0] + `SWDT_KEY_ADD;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st.key <= SEED;
        end else begin
            st <= next_st;
        end
    end

    assign key = st.key;

    // a serviced key must never repeat the previous one
    key_moves_a: assert property (@(posedge aclk) disable iff (!aresetn)
        advance |=> st.key != $past(st.key))
        else $error("key did not change after service");

endmodule : swdt_key

// ===== src/swdt_top.sv
// swdt_top: software watchdog with AXI4-Lite registers.
// assumes: aclk 200 MHz; irc_clk is the oscillator level, synchronous
// to aclk; reset_req and irq go to the reset and interrupt logic.
//
// How it works
// - In immediate mode an expiry without service requests a reset.
// - In interrupt-first mode the first expiry raises irq and reloads; the next one before a service resets.
// - The down counter advances only on rising edges of the oscillator input.
// - Fixed service is 0xA602 then 0xB480 to the service register, which reloads the counter.
// - Keyed service reloads only when the written value equals the key, which then moves on.
// - With hard lock set, writes to control, timeout and window are ignored.
// - The 32-bit timeout register is the period loaded at every reload.
// - Window and key checks can be combined, testing both time and value of a service.
// - Periods convert to counts at 16 MHz less 6 percent; expiry on the tick after zero can still run long by one oscillator period.
// - With the oscillator stopped and no service writes, the counter holds and no irq or reset occurs.
`timescale 1ns/10ps
`include "swdt_defs.svh"
module swdt_top
    import swdt_pkg::*;
#(
    parameter int unsigned PERIOD_US     = `SWDT_DEF_PERIOD_US,
    // worst case slow oscillator: period times least frequency
    parameter logic [31:0] TIMEOUT_RESET = 32'(64'(PERIOD_US)
        * 64'(`SWDT_IRC_KHZ) * 64'(100 - `SWDT_IRC_TOL_PCT)
        / 64'(100000)),
    parameter logic [`SWDT_SVC_W-1:0] KEY_SEED = `SWDT_KEY_SEED
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic          irc_clk,
    input  wire logic [31:0]   s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [31:0]   s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    output logic               irq,
    output logic               reset_req
);

    // a zero timeout would expire before software could ever service
    if (TIMEOUT_RESET == 32'h0000_0000) begin : g_chk
        $error("TIMEOUT_RESET must be non-zero");
    end

    swdt_state_s               st;
    swdt_state_s               next_st;
    logic [`SWDT_SVC_W-1:0]    key;
    logic                      key_adv;
    logic                      wr_fire;
    logic                      svc_wr;
    logic                      irc_edge;
    logic                      early;
    logic                      reload;
    logic                      expire;
    logic                      en;
    logic [`SWDT_SVC_W-1:0]    wv;
    logic [31:0]               wmask;

    swdt_key #(
        .SEED    (KEY_SEED)
    ) u_key (
        .aclk    (aclk),
        .aresetn (aresetn),
        .advance (key_adv),
        .key     (key)
    );

    // byte-lane mask of the pending write
    for (genvar i = 0; i < 4; i++) begin : g_mask
        assign wmask[8*i +: 8] = {8{st.wstrb[i]}};
    end

    // bus slave, register writes, service checking and counting
    always_comb begin
        next_st  = st;
        key_adv  = 1'b0;
        reload   = 1'b0;
        expire   = 1'b0;
        en       = st.ctrl[`SWDT_CR_EN];
        wv       = st.wdata[`SWDT_SVC_W-1:0];
        wr_fire  = st.aw_got && st.w_got && !st.bvalid;
        svc_wr   = wr_fire && st.waddr == `SWDT_OFF_SERVICE
                   && st.wstrb[1:0] == 2'b11 && en;
        irc_edge = irc_clk && !st.irc_prev;
        early    = st.ctrl[`SWDT_CR_WIN] && st.count > st.window;
        next_st.irc_prev = irc_clk;

        // address and data are caught separately, in either order
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_got = 1'b1;
            next_st.waddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_got = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end

        // register write once both halves are in
        if (wr_fire) begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = `SWDT_RESP_OKAY;
            case (st.waddr)
                `SWDT_OFF_CTRL: begin
                    if (!st.ctrl[`SWDT_CR_LOCK]) begin
                        next_st.ctrl = (st.ctrl & ~wmask[`SWDT_CTRL_W-1:0])
                            | (st.wdata[`SWDT_CTRL_W-1:0]
                               & wmask[`SWDT_CTRL_W-1:0]);
                    end
                end
                `SWDT_OFF_TIMEOUT: begin
                    if (!st.ctrl[`SWDT_CR_LOCK]) begin
                        next_st.timeout = (st.timeout & ~wmask)
                                          | (st.wdata & wmask);
                    end
                end
                `SWDT_OFF_WINDOW: begin
                    if (!st.ctrl[`SWDT_CR_LOCK]) begin
                        next_st.window = (st.window & ~wmask)
                                         | (st.wdata & wmask);
                    end
                end
                `SWDT_OFF_SERVICE, `SWDT_OFF_COUNT,
                `SWDT_OFF_STATUS: begin
                    next_st.bresp = `SWDT_RESP_OKAY;
                end
                default: begin
                    next_st.bresp = `SWDT_RESP_SLVERR;
                end
            endcase
        end

        // service checking: timing first, then value
        if (svc_wr) begin
            if (early) begin
                expire = 1'b1;
                next_st.svc = SWDT_SVC_IDLE;
            end else if (st.ctrl[`SWDT_CR_KEYED]) begin
                if (wv == key) begin
                    reload  = 1'b1;
                    key_adv = 1'b1;
                end else begin
                    expire = 1'b1;
                end
            end else begin
                case (st.svc)
                    SWDT_SVC_IDLE: begin
                        if (wv == `SWDT_SVC_FIRST) begin
                            next_st.svc = SWDT_SVC_ARMED;
                        end
                    end
                    SWDT_SVC_ARMED: begin
                        if (wv == `SWDT_SVC_SECOND) begin
                            reload      = 1'b1;
                            next_st.svc = SWDT_SVC_IDLE;
                        end else if (wv != `SWDT_SVC_FIRST) begin
                            next_st.svc = SWDT_SVC_IDLE;
                        end
                    end
                    default: begin
                        next_st.svc = SWDT_SVC_IDLE;
                    end
                endcase
            end
        end

        // down counter; disabled it simply tracks the period
        if (!en) begin
            next_st.count = st.timeout;
            next_st.svc   = SWDT_SVC_IDLE;
        end else if (reload) begin
            next_st.count = st.timeout;
            next_st.irq   = 1'b0;
        end else if (irc_edge) begin
            if (st.count == 32'h0000_0000) begin
                expire = 1'b1;
            end else begin
                next_st.count = st.count - 32'h0000_0001;
            end
        end

        // expiry reaction; expiry set wins over any clear this cycle
        if (expire) begin
            if (st.ctrl[`SWDT_CR_INTF] && !st.irq) begin
                next_st.irq   = 1'b1;
                next_st.count = st.timeout;
                next_st.svc   = SWDT_SVC_IDLE;
            end else begin
                next_st.rst_req = 1'b1;
            end
        end

        // read channel
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = `SWDT_RESP_OKAY;
            case (s_axi_araddr)
                `SWDT_OFF_CTRL:    next_st.rdata = 32'(st.ctrl);
                `SWDT_OFF_TIMEOUT: next_st.rdata = st.timeout;
                `SWDT_OFF_WINDOW:  next_st.rdata = st.window;
                `SWDT_OFF_SERVICE: next_st.rdata = 32'h0000_0000;
                `SWDT_OFF_COUNT:   next_st.rdata = st.count;
                `SWDT_OFF_STATUS: begin
                    next_st.rdata = 32'h0000_0000;
                    next_st.rdata[`SWDT_ST_IRQ] = st.irq;
                    next_st.rdata[`SWDT_ST_RST] = st.rst_req;
                    next_st.rdata[`SWDT_ST_ARM] = st.svc == SWDT_SVC_ARMED;
                end
                default: begin
                    next_st.rdata = 32'h0000_0000;
                    next_st.rresp = `SWDT_RESP_SLVERR;
                end
            endcase
        end

        // one write and one read in flight keeps ready simple
        next_st.awready = !next_st.aw_got && !next_st.bvalid;
        next_st.wready  = !next_st.w_got && !next_st.bvalid;
        next_st.arready = !next_st.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st          <= '0;
            st.svc      <= SWDT_SVC_IDLE;
            st.ctrl     <= `SWDT_CTRL_RESET;
            st.window   <= `SWDT_WINDOW_RESET;
            st.timeout  <= TIMEOUT_RESET;
            st.count    <= TIMEOUT_RESET;
            st.awready  <= 1'b1;
            st.wready   <= 1'b1;
            st.arready  <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign s_axi_awready = st.awready;
    assign s_axi_wready  = st.wready;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rresp   = st.rresp;
    assign s_axi_rdata   = st.rdata;
    assign irq           = st.irq;
    assign reset_req     = st.rst_req;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_tick_out;
        en && irc_edge && !svc_wr && st.count == 32'h0000_0000;
    endsequence

    sequence s_armed_second;
        st.svc == SWDT_SVC_ARMED ##1 (st.svc == SWDT_SVC_ARMED && svc_wr
            && !early && !st.ctrl[`SWDT_CR_KEYED] && wv == `SWDT_SVC_SECOND);
    endsequence

    immediate_reset_a: assert property (
        s_tick_out and !st.ctrl[`SWDT_CR_INTF] |=> reset_req)
        else $error("no reset on expiry in immediate mode");

    first_expiry_irq_a: assert property (
        s_tick_out and st.ctrl[`SWDT_CR_INTF] && !st.irq
        |=> irq && !reset_req && st.count == $past(st.timeout))
        else $error("first expiry did not raise irq and reload");

    second_expiry_a: assert property (
        s_tick_out and st.irq |=> reset_req)
        else $error("second expiry did not reset");

    osc_hold_a: assert property (
        en && !irc_edge && !svc_wr && !reset_req
        |=> $stable(st.count) && !$rose(reset_req) && !$rose(irq))
        else $error("counter moved without oscillator edge");

    fixed_pair_a: assert property (
        s_armed_second |=> st.count == $past(st.timeout)
            && st.svc == SWDT_SVC_IDLE)
        else $error("fixed pair did not reload");

    keyed_ok_a: assert property (
        svc_wr && st.ctrl[`SWDT_CR_KEYED] && !early && wv == key
        |=> st.count == $past(st.timeout) && !$rose(reset_req))
        else $error("matching key did not reload");

    lock_holds_a: assert property (
        wr_fire && st.ctrl[`SWDT_CR_LOCK]
        |=> $stable(st.ctrl) && $stable(st.timeout)
            && $stable(st.window))
        else $error("locked configuration changed");

    early_service_a: assert property (
        svc_wr && early |=> $rose(irq) || reset_req)
        else $error("early service not treated as expiry");

endmodule : swdt_top

// ===== tb/swdt_tb.sv
// swdt_tb: self-checking bench for the software watchdog.
// assumes: swdt_pkg and swdt_top compiled first; the bench makes the
// oscillator ticks itself, so counting is fully under its control.
`timescale 1ns/10ps
`include "swdt_defs.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
    $display("unexpected %s expected %h seen %h", nm, ex, got); \
    err_count++; end end

module swdt_tb
    import swdt_pkg::*;
;
    localparam logic [15:0] KEY0  = 16'hC3A5; // arbitrary seed value
    localparam logic [31:0] EN    = 32'h0000_0001;
    localparam logic [31:0] LOCK  = 32'h0000_0002;
    localparam logic [31:0] INTF  = 32'h0000_0004;
    localparam logic [31:0] KEYED = 32'h0000_0008;
    localparam logic [31:0] WIN   = 32'h0000_0010;
    localparam logic [1:0]  OK    = `SWDT_RESP_OKAY;
    localparam logic [1:0]  SERR  = `SWDT_RESP_SLVERR;
    // shortest period, counted at the slowest oscillator the rule allows
    localparam int unsigned PER_US  = 1;
    localparam int unsigned LOW_KHZ = `SWDT_IRC_KHZ
        - `SWDT_IRC_KHZ * `SWDT_IRC_TOL_PCT / 100;
    localparam logic [31:0] TO_RST  = 32'(PER_US * LOW_KHZ / 1000);

    logic        aclk, aresetn, irc;
    logic [31:0] awaddr, wdata, araddr, rdata, t, w;
    logic [3:0]  wstrb, strb;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, irq, reset_req;
    logic [1:0]  bresp, rresp;
    logic [15:0] key;
    int          err_count, n_checks, n;

    swdt_top #(.PERIOD_US(PER_US), .KEY_SEED(KEY0)) u_swdt_top (
        .aclk(aclk), .aresetn(aresetn), .irc_clk(irc),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .irq(irq), .reset_req(reset_req));

    // 200 MHz clock
    always #2.5 aclk = ~aclk;

    // software's copy of the key generator, never read from the design
    function automatic logic [15:0] next_key(input logic [15:0] k);
        return 16'(k * 16'h0011 + 16'h0003);
    endfunction : next_key

    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    // two edges of reset also restart the key sequence
    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        key = KEY0;
    endtask : do_reset

    // one oscillator period: two cycles high, two low
    task automatic tick(input int cnt);
        repeat (cnt) begin
            @(posedge aclk);
            irc <= 1'b1;
            repeat (2) @(posedge aclk);
            irc <= 1'b0;
            @(posedge aclk);
        end
    endtask : tick

    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [31:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int         k;
        logic [1:0] r;
        k = 0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= strb;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && k < 50);
        r = bresp;
        bready <= 1'b0;
        if (k >= 50) err_count++;
        `CHK("bresp", er, r)
    endtask : wr

    task automatic rd(input logic [31:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int k;
        k = 0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && k < 50);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (k >= 50) err_count++;
    endtask : rd

    task automatic rchk(input logic [31:0] a, input logic [31:0] ex);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        `CHK("rdata", ex, d)
        `CHK("rresp", OK, r)
    endtask : rchk

    // outputs move one edge after their cause; let them land
    task automatic settle();
        repeat (3) @(posedge aclk);
    endtask : settle

    // watchdog: every scenario is a few thousand cycles at most
    initial begin
        repeat (20000) @(posedge aclk);
        $display("unexpected timeout expected end seen hang");
        err_count++;
        end_of_test();
    end

    // main sequence
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        aclk = 0; aresetn = 0; irc = 0; awaddr = 0; wdata = 0; wstrb = 0;
        awvalid = 0; wvalid = 0; bready = 0; araddr = 0; arvalid = 0;
        rready = 0; err_count = 0; n_checks = 0; key = KEY0;
        strb = 4'hF;
        void'($urandom(62));
        do_reset();
        // reset values and an unmapped place
        rchk(`SWDT_OFF_CTRL, 32'h0000_0000);
        rchk(`SWDT_OFF_TIMEOUT, TO_RST);
        rchk(`SWDT_OFF_WINDOW, 32'h0000_0000);
        rchk(`SWDT_OFF_STATUS, 32'h0000_0000);
        rd(32'h0000_0018, d, r);
        `CHK("rresp", SERR, r)
        wr(32'h0000_0018, 32'h0000_0001, SERR);
        // one byte lane only: the other lanes keep their old value
        strb = 4'h1;
        wr(`SWDT_OFF_TIMEOUT, 32'hFFFF_FF2A, OK);
        rchk(`SWDT_OFF_TIMEOUT, {TO_RST[31:8], 8'h2A});
        strb = 4'hF;
        // fixed pair: partial and broken pairs must not reload
        for (int i = 0; i < 3; i++) begin
            t = 32'd10 + 32'($urandom % 20);
            n = 1 + int'($urandom % 8);
            wr(`SWDT_OFF_TIMEOUT, t, OK);
            wr(`SWDT_OFF_CTRL, EN, OK);
            rchk(`SWDT_OFF_COUNT, t);
            tick(n);
            rchk(`SWDT_OFF_COUNT, t - 32'(n));
            repeat (20) @(posedge aclk);
            rchk(`SWDT_OFF_COUNT, t - 32'(n));
            wr(`SWDT_OFF_SERVICE, 32'h0000_A602, OK);
            rchk(`SWDT_OFF_STATUS, 32'h0000_0004);
            wr(`SWDT_OFF_SERVICE, 32'(16'h1234 + i), OK);
            wr(`SWDT_OFF_SERVICE, 32'h0000_B480, OK);
            rchk(`SWDT_OFF_COUNT, t - 32'(n));
            wr(`SWDT_OFF_SERVICE, 32'h0000_A602, OK);
            wr(`SWDT_OFF_SERVICE, 32'h0000_A602, OK);
            wr(`SWDT_OFF_SERVICE, 32'h0000_B480, OK);
            rchk(`SWDT_OFF_COUNT, t);
            wr(`SWDT_OFF_CTRL, 32'h0000_0000, OK);
        end
        // immediate reaction: silent until the tick after zero
        do_reset();
        t = 32'd5 + 32'($urandom % 8);
        wr(`SWDT_OFF_TIMEOUT, t, OK);
        wr(`SWDT_OFF_CTRL, EN, OK);
        tick(int'(t));
        rchk(`SWDT_OFF_COUNT, 32'h0000_0000);
        `CHK("reset_req", 1'b0, reset_req)
        tick(1);
        settle();
        `CHK("reset_req", 1'b1, reset_req)
        `CHK("irq", 1'b0, irq)
        rchk(`SWDT_OFF_STATUS, 32'h0000_0002);
        // interrupt first, service, then two expiries in a row
        do_reset();
        wr(`SWDT_OFF_TIMEOUT, t, OK);
        wr(`SWDT_OFF_CTRL, EN | INTF, OK);
        tick(int'(t) + 1);
        settle();
        `CHK("irq", 1'b1, irq)
        `CHK("reset_req", 1'b0, reset_req)
        rchk(`SWDT_OFF_COUNT, t);
        wr(`SWDT_OFF_SERVICE, 32'h0000_A602, OK);
        wr(`SWDT_OFF_SERVICE, 32'h0000_B480, OK);
        settle();
        `CHK("irq", 1'b0, irq)
        tick(int'(t) + 1);
        settle();
        `CHK("reset_req", 1'b0, reset_req)
        tick(int'(t) + 1);
        settle();
        `CHK("reset_req", 1'b1, reset_req)
        // keyed service: a run of good keys, then one wrong key
        do_reset();
        t = 32'd12 + 32'($urandom % 10);
        wr(`SWDT_OFF_TIMEOUT, t, OK);
        wr(`SWDT_OFF_CTRL, EN | KEYED, OK);
        for (int i = 0; i < 4; i++) begin
            tick(1 + int'($urandom % 10));
            wr(`SWDT_OFF_SERVICE, {16'h0000, key}, OK);
            key = next_key(key);
            rchk(`SWDT_OFF_COUNT, t);
        end
        `CHK("reset_req", 1'b0, reset_req)
        wr(`SWDT_OFF_SERVICE, {16'h0000, key ^ 16'h0100}, OK);
        settle();
        `CHK("reset_req", 1'b1, reset_req)
        // window plus key: good key in the window, then one too early
        do_reset();
        t = 32'd20;
        w = 32'd4 + 32'($urandom % 6);
        wr(`SWDT_OFF_TIMEOUT, t, OK);
        wr(`SWDT_OFF_WINDOW, w, OK);
        wr(`SWDT_OFF_CTRL, EN | KEYED | WIN, OK);
        tick(int'(t - w));
        wr(`SWDT_OFF_SERVICE, {16'h0000, key}, OK);
        key = next_key(key);
        rchk(`SWDT_OFF_COUNT, t);
        `CHK("reset_req", 1'b0, reset_req)
        tick(1);
        wr(`SWDT_OFF_SERVICE, {16'h0000, key}, OK);
        settle();
        `CHK("reset_req", 1'b1, reset_req)
        // hard lock: writes answered but ignored, watchdog keeps going
        do_reset();
        wr(`SWDT_OFF_CTRL, EN | LOCK, OK);
        rchk(`SWDT_OFF_CTRL, EN | LOCK);
        wr(`SWDT_OFF_TIMEOUT, 32'h0000_0063, OK);
        wr(`SWDT_OFF_WINDOW, 32'h0000_0005, OK);
        wr(`SWDT_OFF_CTRL, 32'h0000_0000, OK);
        rchk(`SWDT_OFF_TIMEOUT, TO_RST);
        rchk(`SWDT_OFF_WINDOW, 32'h0000_0000);
        rchk(`SWDT_OFF_CTRL, EN | LOCK);
        tick(int'(TO_RST) + 1);
        settle();
        `CHK("reset_req", 1'b1, reset_req)
        end_of_test();
    end
endmodule : swdt_tb
